/* File: hw/rqcc_top.sv */
// receive-queue command register with threshold status, dma mode and events
// assumes queue-side signals on clk; host strobes arrive as a plain port
`timescale 1ns/10ps
module rqcc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [9:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // dma data port, strobes only, address ignored in dma mode
  input  wire logic        dma_rd,
  input  wire logic        dma_wr,
  input  wire logic [1:0]  dma_size,
  input  wire logic [7:0]  dma_wdata,
  output logic      [7:0]  dma_rdata,
  output logic             dma_mode,
  // receive queue conditions
  input  wire logic        dur_over,
  input  wire logic        byte_over,
  input  wire logic        frm_over,
  input  wire logic        frame_read_done,
  input  wire logic        err_free_done,
  // receive queue controls
  output logic             ip_align_pad_enable,
  output logic             auto_dequeue_advance,
  output logic             error_frame_release,
  output logic             rx_irq_request,
  // transmit buffer write path
  output logic             tx_buf_wr,
  output logic      [10:0] tx_buf_addr,
  output logic      [7:0]  tx_buf_wdata,
  // event interrupt
  output logic             irq
);
  logic [15:0] cmd;
  logic [2:0]  hit;
  logic [2:0]  thr_en;
  logic [2:0]  thr_req;
  logic        pad_en;
  logic        deq_en;
  logic        dma_start;
  logic        err_rel;
  logic [10:0] rx_ptr;
  logic        ptr_auto;
  logic [10:0] tx_ptr;
  logic [rqcc_pkg::EVT_W-1:0] evt_status;
  logic [rqcc_pkg::EVT_W-1:0] evt_enable;
  logic [rqcc_pkg::EVT_W-1:0] evt_pulse;
  logic        cmd_wr;
  logic        isr_wr;
  logic        reg_open;
  logic        rel_prev;
  logic        dma_prev;
  logic        thr_prev;
  logic [10:0] step;
  logic [15:0] next_rdata;
  logic [2:0]  cond;

  function automatic logic [10:0] size_step(input logic [1:0] sz);
    case (sz)
      rqcc_pkg::SZ_BYTE:  size_step = 11'h001;
      rqcc_pkg::SZ_WORD:  size_step = 11'h002;
      default:            size_step = 11'h004;
    endcase
  endfunction

  function automatic logic hits(input logic [9:0] a, input logic [9:0] target);
    hits = (a == target);
  endfunction

  // only the command register answers while dma is active
  assign reg_open = ~cmd[rqcc_pkg::BIT_DMA_START];
  assign cmd_wr   = wr & hits(addr, rqcc_pkg::ADDR_RX_CMD);
  assign isr_wr   = wr & reg_open & hits(addr, rqcc_pkg::ADDR_ISR);
  assign step     = size_step(dma_size);
  assign cond     = {dur_over, byte_over, frm_over};

  // command word as stored, before the read path masks it; reserved bits never store
  assign cmd = {6'h00, pad_en, 1'b0, thr_en, deq_en, dma_start, 2'h0, err_rel};

  // two-byte pad ahead of each frame header
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pad_en <= rqcc_pkg::CMD_RESET[rqcc_pkg::BIT_IP_PAD];
    end
    else if (cmd_wr)
    begin
      pad_en <= wdata[rqcc_pkg::BIT_IP_PAD];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      deq_en <= rqcc_pkg::CMD_RESET[rqcc_pkg::BIT_AUTO_DEQ];
    end
    else if (cmd_wr)
    begin
      deq_en <= wdata[rqcc_pkg::BIT_AUTO_DEQ];
    end
  end

  // dma start is write-only and stays set until the host writes 0
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dma_start <= rqcc_pkg::CMD_RESET[rqcc_pkg::BIT_DMA_START];
    end
    else if (cmd_wr)
    begin
      dma_start <= wdata[rqcc_pkg::BIT_DMA_START];
    end
  end

  // writing 0 cannot cancel a pending release; only the free completion ends it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      err_rel <= rqcc_pkg::CMD_RESET[rqcc_pkg::BIT_ERR_REL];
    end
    else if (cmd_wr && wdata[rqcc_pkg::BIT_ERR_REL])
    begin
      err_rel <= 1'b1;
    end
    else if (err_free_done)
    begin
      err_rel <= 1'b0;
    end
  end

  // one channel per threshold: enable, cause snapshot and masked request
  for (genvar g = 0; g < 3; g++)
  begin : g_thr
    logic en_q;
    logic hit_q;

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        en_q <= rqcc_pkg::CMD_RESET[rqcc_pkg::BIT_FRM_EN + g];
      end
      else if (cmd_wr)
      begin
        en_q <= wdata[rqcc_pkg::BIT_FRM_EN + g];
      end
    end

    // cause is a snapshot, so software reads it after the condition has gone
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        hit_q <= 1'b0;
      end
      else if (isr_wr && wdata[rqcc_pkg::BIT_ISR_RX])
      begin
        hit_q <= cond[g] & en_q;
      end
    end

    assign thr_en[g]  = en_q;
    assign hit[g]     = hit_q;
    assign thr_req[g] = cond[g] & en_q;
  end

  // receive frame pointer, loaded by a host write before a dma read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_ptr   <= rqcc_pkg::PTR_RESET;
      ptr_auto <= 1'b0;
    end
    else if (wr && reg_open && hits(addr, rqcc_pkg::ADDR_RX_PTR))
    begin
      rx_ptr   <= wdata[10:0];
      ptr_auto <= wdata[rqcc_pkg::BIT_PTR_AUTO];
    end
    else if (dma_mode && dma_rd && ptr_auto)
    begin
      rx_ptr <= rx_ptr + step;
    end
  end

  // transmit pointer advances on every dma write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_ptr <= rqcc_pkg::PTR_RESET;
    end
    else if (!dma_mode)
    begin
      tx_ptr <= rqcc_pkg::PTR_RESET;
    end
    else if (dma_wr)
    begin
      tx_ptr <= tx_ptr + step;
    end
  end

  // dma strobes reach the buffers regardless of address
  assign tx_buf_wr    = dma_mode & dma_wr;
  assign tx_buf_addr  = tx_ptr;
  assign tx_buf_wdata = dma_wdata;

  rqcc_buf u_rx_buf (
    .clk     (clk),
    .wr_en   (1'b0),
    .wr_addr (rqcc_pkg::PTR_RESET),
    .wr_data (8'h00),
    .rd_en   (dma_mode & dma_rd),
    .rd_addr (rx_ptr),
    .rd_data (dma_rdata)
  );

  // register read path; blocked registers read as zero during dma
  always_comb
  begin
    next_rdata = rqcc_pkg::RD_UNMAPPED;
    if (hits(addr, rqcc_pkg::ADDR_RX_CMD))
    begin
      next_rdata = cmd & rqcc_pkg::CMD_RW_MASK;
      next_rdata[rqcc_pkg::BIT_DMA_START] = 1'b0;
      next_rdata[rqcc_pkg::BIT_DUR_HIT]   = hit[2];
      next_rdata[rqcc_pkg::BIT_BYTE_HIT]  = hit[1];
      next_rdata[rqcc_pkg::BIT_FRM_HIT]   = hit[0];
    end
    else if (reg_open)
    begin
      case (addr)
        rqcc_pkg::ADDR_EVT_STATUS: next_rdata = {13'h0, evt_status};
        rqcc_pkg::ADDR_EVT_ENABLE: next_rdata = {13'h0, evt_enable};
        rqcc_pkg::ADDR_RX_PTR:     next_rdata = {1'b0, ptr_auto, 3'h0, rx_ptr};
        default:                   next_rdata = rqcc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= 16'h0000;
    end
    else if (rd)
    begin
      rdata <= next_rdata;
    end
    else
    begin
      rdata <= 16'h0000;
    end
  end

  // edge history for event pulses, one register per watched level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rel_prev <= 1'b0;
    end
    else
    begin
      rel_prev <= err_rel;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dma_prev <= 1'b0;
    end
    else
    begin
      dma_prev <= dma_start;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      thr_prev <= 1'b0;
    end
    else
    begin
      thr_prev <= rx_irq_request;
    end
  end

  assign evt_pulse[rqcc_pkg::EVT_THRESH]    = rx_irq_request & ~thr_prev;
  assign evt_pulse[rqcc_pkg::EVT_DMA_END]   = dma_prev & ~cmd[rqcc_pkg::BIT_DMA_START];
  assign evt_pulse[rqcc_pkg::EVT_ERR_FREED] = rel_prev & ~cmd[rqcc_pkg::BIT_ERR_REL];

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      evt_status <= '0;
    end
    else if (wr && reg_open && hits(addr, rqcc_pkg::ADDR_EVT_CLEAR))
    begin
      evt_status <= (evt_status & ~wdata[rqcc_pkg::EVT_W-1:0]) | evt_pulse;
    end
    else
    begin
      evt_status <= evt_status | evt_pulse;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      evt_enable <= '0;
    end
    else if (wr && reg_open && hits(addr, rqcc_pkg::ADDR_EVT_ENABLE))
    begin
      evt_enable <= wdata[rqcc_pkg::EVT_W-1:0];
    end
  end

  assign irq = |(evt_status & evt_enable);

  // outputs to the receive queue
  assign dma_mode             = cmd[rqcc_pkg::BIT_DMA_START];
  assign ip_align_pad_enable  = cmd[rqcc_pkg::BIT_IP_PAD];
  assign auto_dequeue_advance = cmd[rqcc_pkg::BIT_AUTO_DEQ] & frame_read_done;
  assign error_frame_release  = cmd[rqcc_pkg::BIT_ERR_REL];
  assign rx_irq_request       = |thr_req;
endmodule

/* File: pkg/rqcc_pkg.sv */
// package for the receive-queue command register block
// assumes a 125 MHz core clock and a simple strobe register port
package rqcc_pkg;
  localparam logic [9:0]  ADDR_RX_CMD     = 10'h182;
  localparam logic [9:0]  ADDR_ISR        = 10'h092;
  localparam logic [9:0]  ADDR_EVT_STATUS = 10'h1f0;
  localparam logic [9:0]  ADDR_EVT_CLEAR  = 10'h1f2;
  localparam logic [9:0]  ADDR_EVT_ENABLE = 10'h1f4;
  localparam logic [9:0]  ADDR_RX_PTR     = 10'h186;
  localparam int          BIT_DUR_HIT     = 12;
  localparam int          BIT_BYTE_HIT    = 11;
  localparam int          BIT_FRM_HIT     = 10;
  localparam int          BIT_IP_PAD      = 9;
  localparam int          BIT_DUR_EN      = 7;
  localparam int          BIT_BYTE_EN     = 6;
  localparam int          BIT_FRM_EN      = 5;
  localparam int          BIT_AUTO_DEQ    = 4;
  localparam int          BIT_DMA_START   = 3;
  localparam int          BIT_ERR_REL     = 0;
  localparam int          BIT_ISR_RX      = 13;
  localparam int          BIT_PTR_AUTO    = 14;
  localparam logic [15:0] CMD_RW_MASK     = 16'h02f1;
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [10:0] PTR_RESET       = 11'h000;
  localparam logic [15:0] RD_UNMAPPED     = 16'h0000;
  localparam int          EVT_W           = 3;
  localparam int          EVT_THRESH      = 0;
  localparam int          EVT_DMA_END     = 1;
  localparam int          EVT_ERR_FREED   = 2;
  localparam int          BUF_DEPTH       = 2048;
  localparam int          BUF_AW          = 11;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} rqcc_size_e;
endpackage

/* File: hw/rqcc_buf.sv */
// frame buffer memory, byte wide, registered read data
// assumes one port per use, single clock
`timescale 1ns/10ps
module rqcc_buf (
  // clock
  input  wire logic                        clk,
  // write side
  input  wire logic                        wr_en,
  input  wire logic [rqcc_pkg::BUF_AW-1:0] wr_addr,
  input  wire logic [7:0]                  wr_data,
  // read side
  input  wire logic                        rd_en,
  input  wire logic [rqcc_pkg::BUF_AW-1:0] rd_addr,
  output logic      [7:0]                  rd_data
);
  logic [7:0] mem [rqcc_pkg::BUF_DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

/* File: test/rqcc_props.sv */
// assertions on the receive-queue command block ports
// assumes binding to rqcc_top, single clock domain
`timescale 1ns/10ps
module rqcc_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // register port
  input wire logic [9:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // dma and queue side
  input wire logic        dma_wr,
  input wire logic        dma_mode,
  input wire logic        dur_over,
  input wire logic        byte_over,
  input wire logic        frm_over,
  input wire logic        frame_read_done,
  input wire logic        err_free_done,
  input wire logic        ip_align_pad_enable,
  input wire logic        auto_dequeue_advance,
  input wire logic        error_frame_release,
  input wire logic        rx_irq_request,
  input wire logic        tx_buf_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic cw;
  assign cw = wr && addr == rqcc_pkg::ADDR_RX_CMD;
  chk_pad_follows: assert property (cw |=> ip_align_pad_enable == $past(wdata[9]))
    else $error("pad enable did not follow write");
  chk_dma_enter: assert property (cw && wdata[3] |=> dma_mode)
    else $error("dma mode not entered");
  chk_dma_leave: assert property (cw && !wdata[3] |=> !dma_mode)
    else $error("dma mode not left");
  chk_tx_strobe: assert property (tx_buf_wr == (dma_mode && dma_wr))
    else $error("tx write strobe wrong");
  chk_dma_block: assert property (dma_mode && rd && !cw && addr != rqcc_pkg::ADDR_RX_CMD
    |=> rdata == 16'h0000)
    else $error("register read not blocked in dma");
  chk_cmd_reserved: assert property (rd && addr == rqcc_pkg::ADDR_RX_CMD
    |=> (rdata & 16'he10e) == 16'h0000)
    else $error("reserved command bits not zero");
  chk_rel_start: assert property (cw && wdata[0] |=> error_frame_release)
    else $error("release not started");
  chk_rel_done: assert property (err_free_done && !cw |=> !error_frame_release)
    else $error("release did not self clear");
  chk_deq_cause: assert property (auto_dequeue_advance |-> frame_read_done)
    else $error("dequeue without finished frame");
  chk_irq_cause: assert property (!(dur_over || byte_over || frm_over) |-> !rx_irq_request)
    else $error("threshold request without condition");
  cover property (dma_mode ##1 !dma_mode);
  cover property ($fell(error_frame_release));
  cover property (rx_irq_request);
endmodule

bind rqcc_top rqcc_props rqcc_props_i (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .dma_wr(dma_wr), .dma_mode(dma_mode), .dur_over(dur_over), .byte_over(byte_over),
  .frm_over(frm_over), .frame_read_done(frame_read_done), .err_free_done(err_free_done),
  .ip_align_pad_enable(ip_align_pad_enable), .auto_dequeue_advance(auto_dequeue_advance),
  .error_frame_release(error_frame_release), .rx_irq_request(rx_irq_request),
  .tx_buf_wr(tx_buf_wr)
);

/* File: test/rqcc_host.sv */
// host cpu model driving the register port of the command block
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
module rqcc_host (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [9:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata
);
  initial
  begin
    addr = 10'h3ff;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines show the inverse so a stale value is never taken as live
  task automatic bw(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    addr <= ~a;
    wdata <= ~d;
    wr <= 1'b0;
  endtask
  task automatic br(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    addr <= ~a;
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic ptr_zero();
    bw(rqcc_pkg::ADDR_RX_PTR, 16'h4000);
  endtask
  task automatic dma_end();
    bw(rqcc_pkg::ADDR_RX_CMD, 16'h0000);
  endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the receive-queue command block
// assumes the host model owns the register port; queue side driven here
`timescale 1ns/10ps
module tb_top;
  localparam logic [9:0] CMD = rqcc_pkg::ADDR_RX_CMD;
  localparam logic [9:0] ES  = rqcc_pkg::ADDR_EVT_STATUS;
  localparam logic [9:0] EE  = rqcc_pkg::ADDR_EVT_ENABLE;
  logic        clk, nrst, wr, rd, dma_rd, dma_wr, dma_mode, dur_over, byte_over, frm_over;
  logic        frame_read_done, err_free_done, pad, deq, rel, rxirq, tx_wr, irq;
  logic [9:0]  addr;
  logic [15:0] wdata, rdata, r;
  logic [1:0]  dma_size;
  logic [7:0]  dma_wdata, tx_wdata;
  logic [10:0] tx_addr;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  rqcc_host rqcc_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rqcc_top rqcc_top_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .dma_rd(dma_rd), .dma_wr(dma_wr), .dma_size(dma_size), .dma_wdata(dma_wdata),
    .dma_rdata(), .dma_mode(dma_mode), .dur_over(dur_over), .byte_over(byte_over),
    .frm_over(frm_over), .frame_read_done(frame_read_done), .err_free_done(err_free_done),
    .ip_align_pad_enable(pad), .auto_dequeue_advance(deq), .error_frame_release(rel),
    .rx_irq_request(rxirq), .tx_buf_wr(tx_wr), .tx_buf_addr(tx_addr), .tx_buf_wdata(tx_wdata),
    .irq(irq)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [9:0] a, input logic [15:0] exp);
    rqcc_host_i.br(a, r);
    chk(r, exp);
  endtask
  task automatic t_regs();
    rdc(CMD, 16'h0000);
    rqcc_host_i.bw(CMD, 16'hfff6);
    rdc(CMD, 16'h02f0);
    chk({15'h0, pad}, 16'h0001);
    rdc(10'h3fe, 16'h0000);
  endtask
  task automatic t_status();
    rqcc_host_i.bw(CMD, 16'h00e0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      {dur_over, byte_over, frm_over} <= 3'b100 >> i;
      @(negedge clk);
      chk({15'h0, rxirq}, 16'h0001);
      rqcc_host_i.bw(rqcc_pkg::ADDR_ISR, 16'h2000);
      {dur_over, byte_over, frm_over} <= 3'b000;
      // condition already gone: the status must still hold the snapshot
      rdc(CMD, 16'h00e0 | (16'h1000 >> i));
    end
    rqcc_host_i.bw(CMD, 16'h0000);
    @(posedge clk);
    dur_over <= 1'b1;
    @(negedge clk);
    chk({15'h0, rxirq}, 16'h0000);
    rqcc_host_i.bw(rqcc_pkg::ADDR_ISR, 16'h2000);
    dur_over <= 1'b0;
    rdc(CMD, 16'h0000);
  endtask
  task automatic t_rel();
    rqcc_host_i.bw(CMD, 16'h0001);
    rdc(CMD, 16'h0001);
    chk({15'h0, rel}, 16'h0001);
    @(posedge clk);
    err_free_done <= 1'b1;
    @(posedge clk);
    err_free_done <= 1'b0;
    rdc(CMD, 16'h0000);
  endtask
  task automatic t_deq();
    for (int i = 1; i >= 0; i--)
    begin
      rqcc_host_i.bw(CMD, {11'h0, i[0], 4'h0});
      @(posedge clk);
      frame_read_done <= 1'b1;
      @(negedge clk);
      chk({15'h0, deq}, {15'h0, i[0]});
      @(posedge clk);
      frame_read_done <= 1'b0;
    end
  endtask
  task automatic t_dma();
    rqcc_host_i.bw(rqcc_pkg::ADDR_EVT_CLEAR, 16'h0007);
    rqcc_host_i.bw(EE, 16'h0002);
    rqcc_host_i.ptr_zero();
    rqcc_host_i.bw(CMD, 16'h0008);
    rdc(rqcc_pkg::ADDR_RX_PTR, 16'h0000);
    chk({14'h0, dma_mode, irq}, 16'h0002);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      dma_size <= i[1:0];
      dma_rd <= 1'b1;
      @(posedge clk);
      dma_rd <= 1'b0;
    end
    dma_wr <= 1'b1;
    dma_wdata <= 8'h5a;
    @(negedge clk);
    chk({7'h0, tx_wr, tx_wdata}, 16'h015a);
    @(posedge clk);
    dma_wr <= 1'b0;
    @(negedge clk);
    chk({5'h0, tx_addr}, 16'h0004);
    rqcc_host_i.dma_end();
    rdc(rqcc_pkg::ADDR_RX_PTR, 16'h4007);
    chk({5'h0, tx_addr}, 16'h0000);
    rdc(ES, 16'h0002);
    chk({15'h0, irq}, 16'h0001);
    rqcc_host_i.bw(EE, 16'h0000);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    rqcc_host_i.bw(rqcc_pkg::ADDR_EVT_CLEAR, 16'h0002);
    rdc(ES, 16'h0000);
    // with auto-increment off a dma read leaves the pointer alone
    rqcc_host_i.bw(rqcc_pkg::ADDR_RX_PTR, 16'h0003);
    rqcc_host_i.bw(CMD, 16'h0008);
    @(posedge clk);
    dma_rd <= 1'b1;
    @(posedge clk);
    dma_rd <= 1'b0;
    rqcc_host_i.dma_end();
    rdc(rqcc_pkg::ADDR_RX_PTR, 16'h0003);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a hang in any wait ends here after far more cycles than the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  initial
  begin
    nrst = 1'b0;
    {dma_rd, dma_wr, dur_over, byte_over, frm_over, frame_read_done, err_free_done} = 7'h00;
    dma_size = 2'h0;
    dma_wdata = 8'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_status();
    t_rel();
    t_deq();
    t_dma();
    give_verdict();
  end
endmodule
